// File: core/vad_regs_pkg.sv
// register map, field layout and reset values of the page and detector config block
// assumes byte-wide accesses handed over by the control-port engine
`default_nettype none
package vad_regs_pkg;
  localparam int DATA_W = 8;
  localparam int CHAN_N = 4;
  // offsets valid on every page, on page 0 and on page 1
  localparam logic [7:0] PAGE_OFF = 8'h00;
  localparam logic [7:0] CKSUM_OFF = 8'h7E;
  localparam logic [7:0] CFG1_OFF = 8'h1E;
  localparam logic [7:0] CFG2_OFF = 8'h1F;
  localparam logic [7:0] CKSUM_PAGE = 8'h00;
  localparam logic [7:0] CFG_PAGE = 8'h01;
  // reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CKSUM_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h20;
  localparam logic [7:0] CFG2_RST = 8'h08;
  // bits of config two that hold storage; the rest read as zero
  localparam logic [7:0] CFG2_RW_MASK = 8'hD8;
  // field positions
  localparam int POLICY_LSB = 6;
  localparam int CHAN_LSB = 4;
  localparam int CLKSRC_LSB = 2;
  localparam int RATE_LSB = 0;
  localparam int IRQ_BIT = 6;
  localparam int DWR_BIT = 3;
  // power policy codes
  localparam logic [1:0] POL_USER = 2'h0;
  localparam logic [1:0] POL_DET = 2'h1;
  localparam logic [1:0] POL_DET_UP = 2'h2;
  localparam logic [1:0] POL_DET_DOWN = 2'h3;
  // external clock rates in kHz, indexed by the rate field
  localparam logic [14:0] RATE_KHZ0 = 15'h0C00;
  localparam logic [14:0] RATE_KHZ1 = 15'h1800;
  localparam logic [14:0] RATE_KHZ2 = 15'h3000;
  localparam logic [14:0] RATE_KHZ3 = 15'h4800;
endpackage : vad_regs_pkg
`default_nettype wire

// File: core/checksum_accum.sv
// running checksum over register writes
// assumes load and update are never both high (the caller decodes them apart)
`default_nettype none
module checksum_accum #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write events
  input wire logic load,
  input wire logic update,
  input wire logic [W-1:0] addr,
  input wire logic [W-1:0] data,
  // running value
  output logic [W-1:0] sum
);
  logic [W-1:0] sum_r;
  logic [W-1:0] sum_nxt;

  // modulo sum of address and data of each update write, a load replaces the sum with data; carries drop on purpose
  assign sum_nxt = load ? data : (update ? W'(sum_r + addr + data) : sum_r);
  assign sum = sum_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_r <= '0;
    end else begin
      sum_r <= sum_nxt;
    end
  end
endmodule : checksum_accum
`default_nettype wire

// File: core/vad_page_checksum_regs.sv
// page select, transaction checksum and voice detector configuration registers
// assumes the control-port engine delivers one-cycle byte read and write strobes
`default_nettype none
module vad_page_checksum_regs #(
  parameter int CHANNELS = vad_regs_pkg::CHAN_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port from the control-port engine
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // user power controls held elsewhere
  input wire logic detector_enable,
  input wire logic converter_power_on,
  // detector events and interrupt request
  input wire logic voice_detected,
  input wire logic silence_detected,
  input wire logic detector_irq,
  // configuration and state towards the datapath
  output logic [7:0] current_page,
  output logic [CHANNELS-1:0] monitored_channel,
  output logic [1:0] detector_clock_source,
  output logic [14:0] detector_ext_clock_khz,
  output logic adc_power_on,
  output logic detector_active,
  // serial data out pin, interrupt use
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe
);
  logic [7:0] page_r;
  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic adc_on_r;
  logic adc_on_nxt;
  logic user_prev_r;
  logic [7:0] cksum;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire on_cfg_page = (page_r == vad_regs_pkg::CFG_PAGE);
  wire hit_page = (addr == vad_regs_pkg::PAGE_OFF);
  wire hit_cksum = (page_r == vad_regs_pkg::CKSUM_PAGE) && (addr == vad_regs_pkg::CKSUM_OFF);
  wire hit_cfg1 = on_cfg_page && (addr == vad_regs_pkg::CFG1_OFF);
  wire hit_cfg2 = on_cfg_page && (addr == vad_regs_pkg::CFG2_OFF);
  wire wr_page = wr_en && hit_page;
  wire wr_cksum = wr_en && hit_cksum;
  wire wr_cfg1 = wr_en && hit_cfg1;
  wire wr_cfg2 = wr_en && hit_cfg2;

  // -----------------------------------------------------------------
  // field views
  // -----------------------------------------------------------------
  wire [1:0] detector_power_policy = cfg1_r[vad_regs_pkg::POLICY_LSB +: 2];
  wire [1:0] detector_channel_select = cfg1_r[vad_regs_pkg::CHAN_LSB +: 2];
  wire [1:0] detector_ext_clock_rate = cfg1_r[vad_regs_pkg::RATE_LSB +: 2];
  wire serial_out_interrupt_config = cfg2_r[vad_regs_pkg::IRQ_BIT];
  wire detect_while_recording = cfg2_r[vad_regs_pkg::DWR_BIT];

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  // page load and hold
  wire [7:0] page_nxt = wr_page ? wdata : page_r;
  wire [7:0] cfg1_nxt = wr_cfg1 ? wdata : cfg1_r;
  wire [7:0] cfg2_nxt = wr_cfg2 ? (wdata & vad_regs_pkg::CFG2_RW_MASK) : cfg2_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_r <= vad_regs_pkg::PAGE_RST;
      cfg1_r <= vad_regs_pkg::CFG1_RST;
      cfg2_r <= vad_regs_pkg::CFG2_RST;
    end else begin
      page_r <= page_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
    end
  end

  checksum_accum #(
    .W(vad_regs_pkg::DATA_W)
  ) u_cksum (
    .clk(clk),
    .arst_n(arst_n),
    .load(wr_cksum),
    .update(wr_en && !hit_cksum),
    .addr(addr),
    .data(wdata),
    .sum(cksum)
  );

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  // registered readback of page, checksum and config; unmapped offsets return zero
  assign rdata_nxt = !rd_en ? rdata_r :
                     hit_page ? page_r :
                     hit_cksum ? cksum :
                     hit_cfg1 ? cfg1_r :
                     hit_cfg2 ? cfg2_r : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // -----------------------------------------------------------------
  // converter power policy
  // -----------------------------------------------------------------
  // user power is seen by edges so either party can move it under split policies
  wire user_up = converter_power_on && !user_prev_r;
  wire user_down = !converter_power_on && user_prev_r;
  wire det_ups = (detector_power_policy == vad_regs_pkg::POL_DET) ||
                 (detector_power_policy == vad_regs_pkg::POL_DET_UP);
  wire det_downs = (detector_power_policy == vad_regs_pkg::POL_DET) ||
                   (detector_power_policy == vad_regs_pkg::POL_DET_DOWN);
  wire up_evt = det_ups ? voice_detected : user_up;
  wire down_evt = det_downs ? silence_detected : user_down;

  // policy only while the detector is enabled
  assign adc_on_nxt = !detector_enable ? converter_power_on :
                      up_evt ? 1'b1 :
                      down_evt ? 1'b0 : adc_on_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_on_r <= 1'b0;
      user_prev_r <= 1'b0;
    end else begin
      adc_on_r <= adc_on_nxt;
      user_prev_r <= converter_power_on;
    end
  end
  assign adc_power_on = adc_on_r;

  // -----------------------------------------------------------------
  // detector outputs
  // -----------------------------------------------------------------
  // detection pauses during recording unless allowed
  assign detector_active = detector_enable && (!adc_on_r || detect_while_recording);
  // pin carries interrupts only while nothing records
  assign serial_data_out_pin_oe = detector_enable && serial_out_interrupt_config && !adc_on_r;
  assign serial_data_out_pin_o = serial_data_out_pin_oe && detector_irq;

  // clock source straight from the field
  assign detector_clock_source = cfg1_r[vad_regs_pkg::CLKSRC_LSB +: 2];
  assign current_page = page_r;

  assign detector_ext_clock_khz = (detector_ext_clock_rate == 2'h0) ? vad_regs_pkg::RATE_KHZ0 :
                                  (detector_ext_clock_rate == 2'h1) ? vad_regs_pkg::RATE_KHZ1 :
                                  (detector_ext_clock_rate == 2'h2) ? vad_regs_pkg::RATE_KHZ2 :
                                  vad_regs_pkg::RATE_KHZ3;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      assign monitored_channel[g] = detector_enable && (detector_channel_select == 2'(g));
    end
  endgenerate

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  page_hold_a: assert property (!wr_page |=> $stable(page_r))
    else $error("page changed without a page write");
  page_load_a: assert property (wr_page |=> page_r == $past(wdata))
    else $error("page write not taken");
  // load, one idle cycle as the host spaces its strobes, then a checksum read
  cksum_load_a: assert property (wr_cksum ##1 !wr_en
    ##1 (rd_en && hit_cksum && !wr_en) |=> rdata == $past(wdata, 3))
    else $error("checksum load not read back");
  cksum_upd_a: assert property ((wr_en && !hit_cksum)
    |=> cksum == 8'($past(cksum) + $past(addr) + $past(wdata)))
    else $error("checksum not updated on write");
  chan_sel_a: assert property ((wr_cfg1 && detector_enable) ##1 detector_enable
    |-> monitored_channel[$past(wdata[vad_regs_pkg::CHAN_LSB +: 2])])
    else $error("monitored channel wrong");
  resv_zero_a: assert property ((rd_en && hit_cfg2)
    |=> (rdata & ~vad_regs_pkg::CFG2_RW_MASK) == 8'h00)
    else $error("reserved bits not zero");
  det_wake_a: assert property ((detector_enable
    && detector_power_policy == vad_regs_pkg::POL_DET && voice_detected) |=> adc_power_on)
    else $error("detector policy did not power up");
  rec_pause_a: assert property ((adc_power_on && !detect_while_recording)
    |-> !detector_active)
    else $error("detection ran while recording");
  irq_pin_a: assert property ((!serial_out_interrupt_config || adc_power_on)
    |-> !serial_data_out_pin_oe)
    else $error("interrupt on pin when not allowed");
  user_pwr_a: assert property (!detector_enable
    |=> adc_power_on == $past(converter_power_on))
    else $error("user power not followed");

  page_sw_c: cover property (wr_page ##2 wr_cfg1);
  cksum_rd_c: cover property (wr_en ##2 rd_en && hit_cksum);
  det_cycle_c: cover property (voice_detected && det_ups ##[1:20] silence_detected && det_downs);
  irq_pin_c: cover property (serial_data_out_pin_oe && detector_irq);
endmodule : vad_page_checksum_regs
`default_nettype wire

// File: sim/host_port_model.sv
// host side of the register port: one-byte writes and reads
// assumes the bench calls the tasks and the block answers reads one edge later
`default_nettype none
module host_port_model (
  // clock
  input wire logic clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // listed offsets only
  // idle lines show the inverse so a stale value never decodes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    d = rdata;
  endtask : rd
endmodule : host_port_model
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the page, checksum and detector config registers
// assumes the host model drives the register port on falling edges
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_en, rd_en, apo, dact, so_o, so_oe;
  logic [7:0] addr, wdata, rdata, page, cks, rv;
  logic den = 1'b0, cpo = 1'b0, vd = 1'b0, sd = 1'b0, irq = 1'b0;
  logic [3:0] mch;
  logic [1:0] csrc;
  logic [14:0] khz;
  int n_errors = 0;
  int samples_checked = 0;
  int khz_tab [4] = '{3072, 6144, 12288, 18432};
  always #12.5 clk = ~clk;
  host_port_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  vad_page_checksum_regs uut (.clk(clk), .arst_n(arst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .detector_enable(den), .converter_power_on(cpo), .voice_detected(vd),
    .silence_detected(sd), .detector_irq(irq), .current_page(page),
    .monitored_channel(mch), .detector_clock_source(csrc),
    .detector_ext_clock_khz(khz), .adc_power_on(apo), .detector_active(dact),
    .serial_data_out_pin_o(so_o), .serial_data_out_pin_oe(so_oe));
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // every write other than to the checksum folds offset and byte in
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    cks = cks + a + d;
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check(rv, exp);
  endtask : rdc
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // ----------------
  // tests
  // ----------------
  initial begin
    cks = 8'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    rdc(8'h7E, 8'h00);
    check(mch, 4'h0);
    check(so_oe, 1'b0);
    wrc(8'h00, 8'h01);
    check(page, 8'h01);
    rdc(8'h1E, 8'h20);
    rdc(8'h1F, 8'h08);
    wrc(8'h1F, 8'h40);
    rdc(8'h1F, 8'h40);
    $display("test reset values done");
    den = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wrc(8'h1E, 8'(i * 8'h15));
      check(mch, 15'(1 << i));
      check(csrc, 15'(i));
      check(khz, 15'(khz_tab[i]));
    end
    $display("test field codes done");
    wrc(8'h00, 8'h00);
    rdc(8'h7E, cks);
    host.wr(8'h7E, 8'h5A);
    cks = 8'h5A;
    rdc(8'h7E, 8'h5A);
    wrc(8'h00, 8'hFF);
    check(page, 8'hFF);
    rdc(8'h7E, 8'h00);
    rdc(8'h00, 8'hFF);
    wrc(8'h00, 8'h00);
    rdc(8'h7E, cks);
    $display("test page and checksum done");
    wrc(8'h00, 8'h01);
    wrc(8'h1E, 8'h60);
    pulse(vd);
    check(apo, 1'b1);
    pulse(sd);
    check(apo, 1'b0);
    wrc(8'h1E, 8'h20);
    pulse(vd);
    check(apo, 1'b0);
    pulse(cpo);
    check(apo, 1'b1);
    @(negedge clk);
    check(apo, 1'b0);
    // split policy: detector powers up, user powers down
    wrc(8'h1E, 8'hA0);
    pulse(vd);
    check(apo, 1'b1);
    pulse(sd);
    check(apo, 1'b1);
    pulse(cpo);
    check(apo, 1'b1);
    @(negedge clk);
    check(apo, 1'b0);
    // split policy: user powers up, detector powers down
    wrc(8'h1E, 8'hE0);
    pulse(vd);
    check(apo, 1'b0);
    pulse(cpo);
    check(apo, 1'b1);
    @(negedge clk);
    check(apo, 1'b1);
    pulse(sd);
    check(apo, 1'b0);
    $display("test power policy done");
    wrc(8'h1F, 8'h48);
    irq = 1'b1;
    @(negedge clk);
    check(so_oe, 1'b1);
    check(so_o, 1'b1);
    wrc(8'h1F, 8'h08);
    check(so_oe, 1'b0);
    cpo = 1'b1;
    repeat (2) @(negedge clk);
    check(dact, 1'b1);
    wrc(8'h1F, 8'h00);
    check(dact, 1'b0);
    $display("test pin and recording done");
    end_sim();
  end
  // the whole sequence needs well under 400 cycles
  initial begin
    #(25 * 5000);
    n_errors++;
    $display("Error %0t: timeout", $time);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
